/* File: src/scaling_cfg.svh */
/*
 * Constants of the analog input scaling block: object indices, subindex
 * codes, reset values of the coefficients and divider step count.
 * Assumes it is included by bare name from the design files.
 */
`ifndef SCALING_CFG_SVH
`define SCALING_CFG_SVH

// object indices (upper 16 address bits)
`define OBJ_VALUES  16'h3320
`define OBJ_OFFSETS 16'h3321
`define OBJ_MULTS   16'h3322
`define OBJ_DIVS    16'h3323

// subindex codes (lower 8 address bits)
`define SUB_COUNT   8'h00
`define SUB_CH1     8'h01
`define SUB_CH2     8'h02

// channel count, as stored and as reported
`define NUM_CH      2
`define CH_COUNT    32'h0000_0002

// coefficient reset values (identity scaling) and the zero divisor code
`define OFFSET_RST  16'h0000
`define MULT_RST    16'h0001
`define DIV_RST     16'h0001
`define DIV_ZERO    16'h0000

// one divider step per dividend bit
`define DIV_STEPS   6'h22

`endif

/* File: src/scaling_pkg.sv */
/*
 * Types shared by the analog input scaling block and its divider.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package scaling_pkg;

	typedef logic [9:0]         raw_t;
	typedef logic [15:0]        coef_t;
	typedef logic [31:0]        word_t;
	typedef logic [23:0]        addr_t;
	typedef logic signed [33:0] prod_t;

	typedef enum logic {
		ST_IDLE,
		ST_WAIT
	} seq_state_t;

endpackage

/* File: src/scale_divider.sv */
/*
 * Sequential signed divider: 34-bit dividend by 16-bit divisor, quotient
 * truncated toward zero, one step per cycle while ce is high.
 * Assumes the caller never starts it with a zero divisor and never
 * starts it while it is busy.
 */
`include "scaling_cfg.svh"

module scale_divider (
	// clock, reset, freeze
	input  wire logic           clk_sys,
	input  wire logic           rstn,
	input  wire logic           ce,
	// request
	input  wire logic           start,
	input  wire scaling_pkg::prod_t dividend,
	input  wire scaling_pkg::coef_t divisor,
	// answer
	output logic                done,
	output scaling_pkg::word_t  quotient
);
	import scaling_pkg::*;

	logic        busy;
	logic        neg;
	logic [5:0]  steps;
	logic [16:0] rem;
	logic [33:0] quo;
	logic [15:0] dmag;
	logic [16:0] shifted;
	logic [16:0] trial;
	logic [33:0] signed_quo;

	// restoring step on magnitudes; sign is reapplied at the end
	assign shifted = {rem[15:0], quo[33]};
	assign trial = shifted - {1'b0, dmag};
	assign signed_quo = neg ? 34'(-quo) : quo;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			busy <= 1'b0;
			neg <= 1'b0;
			steps <= '0;
			rem <= '0;
			quo <= '0;
			dmag <= '0;
		end else if (ce) begin
			if (start) begin
				busy <= 1'b1;
				neg <= dividend[33] ^ divisor[15];
				steps <= `DIV_STEPS;
				rem <= '0;
				quo <= dividend[33] ? 34'(-dividend) : dividend;
				dmag <= divisor[15] ? 16'(-divisor) : divisor;
			end else if (busy && steps != '0) begin
				steps <= steps - 6'h01;
				rem <= trial[16] ? shifted : trial;
				quo <= {quo[32:0], ~trial[16]};
			end else begin
				busy <= 1'b0;
			end
		end
	end

	// magnitude never passes 31 bits for 10-bit samples and 16-bit factors
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			done <= 1'b0;
			quotient <= '0;
		end else if (ce) begin
			done <= busy && steps == '0 && !start;
			if (busy && steps == '0)
				quotient <= signed_quo[31:0];
		end
	end

endmodule

/* File: src/analog_input_scaling.sv */
/*
 * Analog input scaling: two converter channels, each corrected by a signed
 * offset, multiplied and divided by signed factors, and presented as a
 * signed 32-bit reading behind a small register port.
 * Assumes converter samples arrive as single-cycle strobes synchronous to
 * clk_sys, and a register master that never issues read and write at once.
 */
// The strobed register port is this design's own decision.
// Summary of operation
// - each fitted channel's scaled reading is always readable as signed 32-bit value
// - subindex zero of all four objects reads back a channel count of two
// - signed offset is added to the raw sample before any scaling
// - offset-corrected sample is multiplied by the channel's signed multiplier
// - that product is divided by the channel's signed divisor, then stored; a zero divisor drops the sample unstored
// - default offset, multiplier and divisor give raw converter digits
// - one writable multiplier per channel; second one only when fitted
// - one writable divisor per fitted channel, applied only to that channel
// - second reading exists only on the two-input variant
`include "scaling_cfg.svh"

module analog_input_scaling (
	// clock, reset, freeze
	input  wire logic               clk_sys,
	input  wire logic               rstn,
	input  wire logic               ce,
	// converter samples
	input  wire logic               adc_valid,
	input  wire logic               adc_channel,
	input  wire scaling_pkg::raw_t  adc_data,
	// variant strap
	input  wire logic               second_channel_fitted,
	// register port
	input  wire scaling_pkg::addr_t reg_addr,
	input  wire scaling_pkg::word_t reg_wdata,
	input  wire logic               reg_write,
	input  wire logic               reg_read,
	output scaling_pkg::word_t      reg_rdata,
	// scaled readings
	output scaling_pkg::word_t      scaled_value_1,
	output scaling_pkg::word_t      scaled_value_2
);
	import scaling_pkg::*;

	// ******************************************************
	// storage and decode
	// ******************************************************

	coef_t      offs    [`NUM_CH];
	coef_t      mults   [`NUM_CH];
	coef_t      divs    [`NUM_CH];
	word_t      scaled  [`NUM_CH];
	raw_t       raw     [`NUM_CH];
	logic       pending [`NUM_CH];
	logic       fitted  [`NUM_CH];
	logic [15:0] obj;
	logic [7:0]  sub;
	logic        rd_ok;
	logic        rd_idx;
	word_t       next_rdata;

	seq_state_t state;
	logic        cur;
	logic        next_cur;
	logic        pick;
	logic        take;
	logic        skip;
	logic        div_start;
	logic        div_done;
	logic        finish;
	logic signed [17:0] sum;
	prod_t       dividend;
	word_t       div_q;

	assign obj = reg_addr[23:8];
	assign sub = reg_addr[7:0];
	assign fitted[0] = 1'b1;
	assign fitted[1] = second_channel_fitted;

	// ******************************************************
	// per-channel registers, samples and results
	// ******************************************************

	for (genvar c = 0; c < `NUM_CH; c++) begin : g_ch
		logic hit;
		logic own_sample;

		// the second set of factors is absent on the one-input variant
		assign hit = ce && reg_write && fitted[c] && sub == 8'(c + 1);
		assign own_sample = adc_valid && adc_channel == 1'(c) && fitted[c];

		always_ff @(posedge clk_sys or negedge rstn) begin
			if (!rstn) begin
				offs[c] <= `OFFSET_RST;
				mults[c] <= `MULT_RST;
				divs[c] <= `DIV_RST;
			end else if (hit) begin
				if (obj == `OBJ_OFFSETS)
					offs[c] <= reg_wdata[15:0];
				if (obj == `OBJ_MULTS)
					mults[c] <= reg_wdata[15:0];
				if (obj == `OBJ_DIVS)
					divs[c] <= reg_wdata[15:0];
			end
		end

		// a new sample in the cycle it is taken wins, so it is not lost
		always_ff @(posedge clk_sys or negedge rstn) begin
			if (!rstn) begin
				raw[c] <= '0;
				pending[c] <= 1'b0;
			end else if (ce) begin
				if (own_sample) begin
					raw[c] <= adc_data;
					pending[c] <= 1'b1;
				end else if (take && next_cur == 1'(c)) begin
					pending[c] <= 1'b0;
				end
			end
		end

		always_ff @(posedge clk_sys or negedge rstn) begin
			if (!rstn)
				scaled[c] <= '0;
			else if (finish && cur == 1'(c))
				scaled[c] <= div_q;
		end
	end

	assign scaled_value_1 = scaled[0];
	assign scaled_value_2 = scaled[1];

	// ******************************************************
	// scaling sequencer
	// ******************************************************

	// channel one has priority; at the converter rate both are served
	always_comb begin
		pick = 1'b1;
		next_cur = 1'b0;
		if (pending[0])
			next_cur = 1'b0;
		else if (pending[1])
			next_cur = 1'b1;
		else
			pick = 1'b0;
	end

	assign take = ce && state == ST_IDLE && pick;
	assign skip = divs[next_cur] == `DIV_ZERO;
	assign div_start = take && !skip;
	assign finish = ce && state == ST_WAIT && div_done;

	// offset goes in first, then the multiplier
	assign sum = $signed({8'h00, raw[next_cur]})
		+ $signed({{2{offs[next_cur][15]}}, offs[next_cur]});
	assign dividend = sum * $signed(mults[next_cur]);

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state <= ST_IDLE;
			cur <= 1'b0;
		end else if (ce) begin
			case (state)
				ST_IDLE: begin
					if (div_start) begin
						state <= ST_WAIT;
						cur <= next_cur;
					end
				end
				ST_WAIT: begin
					if (div_done)
						state <= ST_IDLE;
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	scale_divider u_div (
		.clk_sys  (clk_sys),
		.rstn     (rstn),
		.ce       (ce),
		.start    (div_start),
		.dividend (dividend),
		.divisor  (divs[next_cur]),
		.done     (div_done),
		.quotient (div_q)
	);

	// ******************************************************
	// register read port
	// ******************************************************

	assign rd_idx = 1'(sub - `SUB_CH1);
	assign rd_ok = sub != `SUB_COUNT && sub <= `SUB_CH2 && fitted[rd_idx];

	// narrow fields read back zero-extended; unmapped reads give zero
	always_comb begin
		next_rdata = '0;
		if (sub == `SUB_COUNT) begin
			if (obj inside {`OBJ_VALUES, `OBJ_OFFSETS, `OBJ_MULTS,
					`OBJ_DIVS})
				next_rdata = `CH_COUNT;
		end else if (rd_ok) begin
			case (obj)
				`OBJ_VALUES:  next_rdata = scaled[rd_idx];
				`OBJ_OFFSETS: next_rdata = 32'(offs[rd_idx]);
				`OBJ_MULTS:   next_rdata = 32'(mults[rd_idx]);
				`OBJ_DIVS:    next_rdata = 32'(divs[rd_idx]);
				default:      next_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			reg_rdata <= '0;
		else if (ce && reg_read)
			reg_rdata <= next_rdata;
	end

	// ******************************************************
	// checks
	// ******************************************************

	logic signed [17:0] snap_sum;
	coef_t              snap_mult;
	coef_t              snap_div;
	raw_t               snap_raw;
	logic               snap_dflt;
	prod_t              chk_prod;
	logic signed [49:0] chk_rem;
	logic [49:0]        rem_abs;
	logic [49:0]        div_abs;
	logic               rem_ok;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			snap_sum <= '0;
			snap_mult <= '0;
			snap_div <= '0;
			snap_raw <= '0;
			snap_dflt <= 1'b0;
		end else if (div_start) begin
			snap_sum <= sum;
			snap_mult <= mults[next_cur];
			snap_div <= divs[next_cur];
			snap_raw <= raw[next_cur];
			snap_dflt <= offs[next_cur] == `OFFSET_RST
				&& mults[next_cur] == `MULT_RST
				&& divs[next_cur] == `DIV_RST;
		end
	end

	assign chk_prod = snap_sum * $signed(snap_mult);

	always_comb begin
		chk_rem = 50'(chk_prod) - $signed(div_q) * $signed(snap_div);
		rem_abs = chk_rem[49] ? 50'(-chk_rem) : chk_rem;
		div_abs = snap_div[15] ? 50'(-$signed(snap_div))
			: 50'(snap_div);
		rem_ok = rem_abs < div_abs
			&& (chk_rem == '0 || chk_rem[49] == chk_prod[33]);
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);

	property p_value_read;
		ce && reg_read && reg_addr == {`OBJ_VALUES, `SUB_CH1}
			|=> reg_rdata == $past(scaled[0]);
	endproperty
	a_value_read: assert property (p_value_read)
		else $error("channel one reading not returned on read");

	property p_count_read;
		ce && reg_read && sub == `SUB_COUNT
			&& obj inside {`OBJ_VALUES, `OBJ_OFFSETS, `OBJ_MULTS,
				`OBJ_DIVS}
			|=> reg_rdata == `CH_COUNT;
	endproperty
	a_count_read: assert property (p_count_read)
		else $error("channel count did not read as two");

	property p_offset_first;
		finish && snap_mult == `MULT_RST && snap_div == `DIV_RST
			|=> scaled[cur] == 32'(snap_sum);
	endproperty
	a_offset_first: assert property (p_offset_first)
		else $error("unit factors did not yield sample plus offset");

	property p_multiply;
		finish && snap_div == `DIV_RST
			|=> scaled[cur] == chk_prod[31:0];
	endproperty
	a_multiply: assert property (p_multiply)
		else $error("unit divisor did not yield corrected product");

	property p_divide;
		finish |-> rem_ok ##1 scaled[cur] == $past(div_q);
	endproperty
	a_divide: assert property (p_divide)
		else $error("stored quotient does not match product and divisor");

	property p_identity;
		finish && snap_dflt |=> scaled[cur] == 32'(snap_raw);
	endproperty
	a_identity: assert property (p_identity)
		else $error("default factors did not return raw digits");

	property p_mult_write;
		ce && reg_write && second_channel_fitted
			&& reg_addr == {`OBJ_MULTS, `SUB_CH2}
			|=> mults[1] == $past(reg_wdata[15:0]) && $stable(mults[0]);
	endproperty
	a_mult_write: assert property (p_mult_write)
		else $error("second multiplier write went astray");

	property p_div_write;
		ce && reg_write && reg_addr == {`OBJ_DIVS, `SUB_CH1}
			|=> divs[0] == $past(reg_wdata[15:0]) && $stable(divs[1]);
	endproperty
	a_div_write: assert property (p_div_write)
		else $error("first divisor write went astray");

	property p_ch2_absent;
		ce && reg_read && !second_channel_fitted
			&& reg_addr == {`OBJ_VALUES, `SUB_CH2}
			|=> reg_rdata == '0;
	endproperty
	a_ch2_absent: assert property (p_ch2_absent)
		else $error("second reading visible on one-input variant");

	property p_zero_div;
		take && skip |-> !div_start
			##1 state == ST_IDLE && $stable(scaled[0])
			&& $stable(scaled[1]);
	endproperty
	a_zero_div: assert property (p_zero_div)
		else $error("zero divisor changed a reading");

	c_identity: cover property (finish && snap_dflt);
	c_zero_skip: cover property (take && skip);
	c_second: cover property (finish && cur);
	c_negative: cover property (finish && div_q[31]);

endmodule

/* File: testbench/adc_model.sv */
/*
 * Converter model: one-cycle sample strobes, issued on request.
 * Assumes the bench calls send() and clk_sys runs freely.
 */
module adc_model (
	// clock
	input  wire logic          clk_sys,
	// sample stream
	output logic               adc_valid,
	output logic               adc_channel,
	output scaling_pkg::raw_t  adc_data
);
	timeunit 1ns;
	timeprecision 1ps;
	import scaling_pkg::*;

	initial begin
		adc_valid   = 1'b0;
		adc_channel = 1'b0;
		adc_data    = 10'h2AA;
	end

	// outside the strobe the lines show the inverse of the last sample,
	// so a design that latches late sees wrong data, not a stale copy
	task automatic send(logic ch, raw_t d);
		@(posedge clk_sys);
		adc_valid   <= 1'b1;
		adc_channel <= ch;
		adc_data    <= d;
		@(posedge clk_sys);
		adc_valid   <= 1'b0;
		adc_channel <= ~ch;
		adc_data    <= ~d;
	endtask
endmodule

/* File: testbench/analog_input_scaling_bench.sv */
/*
 * Self-checking bench for analog_input_scaling with a converter model.
 * Assumes the package, the config header and the design are compiled first.
 */
`include "scaling_cfg.svh"

module analog_input_scaling_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import scaling_pkg::*;

	logic   clk_sys               = 1'b0;
	logic   rstn                  = 1'b0;
	logic   ce                    = 1'b0;
	logic   second_channel_fitted = 1'b1;
	addr_t  reg_addr              = 24'h00_0000;
	word_t  reg_wdata             = 32'h0000_0000;
	logic   reg_write             = 1'b0;
	logic   reg_read              = 1'b0;
	word_t  reg_rdata;
	word_t  scaled_value_1;
	word_t  scaled_value_2;
	logic   adc_valid;
	logic   adc_channel;
	raw_t   adc_data;
	int     bad_count             = 0;
	int     total_checks          = 0;

	always #4 clk_sys = ~clk_sys;

	analog_input_scaling dut (
		.clk_sys               (clk_sys),
		.rstn                  (rstn),
		.ce                    (ce),
		.adc_valid             (adc_valid),
		.adc_channel           (adc_channel),
		.adc_data              (adc_data),
		.second_channel_fitted (second_channel_fitted),
		.reg_addr              (reg_addr),
		.reg_wdata             (reg_wdata),
		.reg_write             (reg_write),
		.reg_read              (reg_read),
		.reg_rdata             (reg_rdata),
		.scaled_value_1        (scaled_value_1),
		.scaled_value_2        (scaled_value_2)
	);

	adc_model adc (
		.clk_sys     (clk_sys),
		.adc_valid   (adc_valid),
		.adc_channel (adc_channel),
		.adc_data    (adc_data)
	);

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic check(string what, word_t exp, word_t got);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(addr_t a, word_t d);
		@(posedge clk_sys);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk_sys);
		reg_write <= 1'b0;
	endtask

	task automatic rd(addr_t a, word_t exp);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk_sys);
		reg_read <= 1'b0;
		#1;
		check($sformatf("read %h", a), exp, reg_rdata);
	endtask

	// scaling sequence is ~37 cycles per channel; 200 covers both queued
	task automatic wait_val(logic ch, word_t exp);
		word_t v;
		for (int i = 0; i < 200; i++) begin
			@(posedge clk_sys);
			#1;
			v = ch ? scaled_value_2 : scaled_value_1;
			if (v === exp)
				break;
		end
		check(ch ? "scaled 2" : "scaled 1", exp, v);
		rd({`OBJ_VALUES, ch ? `SUB_CH2 : `SUB_CH1}, exp);
	endtask

	function automatic word_t scale(int raw, int off, int mul, int dv);
		return word_t'((raw + off) * mul / dv);
	endfunction

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset_map();
		for (int k = 0; k < 4; k++) begin
			rd({`OBJ_VALUES + 16'(k), `SUB_COUNT}, `CH_COUNT);
		end
		rd({`OBJ_OFFSETS, `SUB_CH1}, 32'h0000_0000);
		rd({`OBJ_MULTS, `SUB_CH2}, 32'h0000_0001);
		rd({`OBJ_DIVS, `SUB_CH1}, 32'h0000_0001);
		rd(24'h33_2401, 32'h0000_0000);
		wr({`OBJ_VALUES, `SUB_CH1}, 32'h0000_1234);
		wr({`OBJ_MULTS, `SUB_COUNT}, 32'h0000_0005);
		rd({`OBJ_VALUES, `SUB_CH1}, 32'h0000_0000);
		rd({`OBJ_MULTS, `SUB_COUNT}, `CH_COUNT);
		@(posedge clk_sys);
		ce <= 1'b0;
		wr({`OBJ_OFFSETS, `SUB_CH1}, 32'h0000_0007);
		@(posedge clk_sys);
		ce <= 1'b1;
		rd({`OBJ_OFFSETS, `SUB_CH1}, 32'h0000_0000);
	endtask

	task automatic t_default();
		adc.send(1'b0, 10'h064);
		wait_val(1'b0, 32'h0000_0064);
		adc.send(1'b1, 10'h3FF);
		wait_val(1'b1, 32'h0000_03FF);
	endtask

	task automatic t_scale();
		wr({`OBJ_OFFSETS, `SUB_CH1}, 32'h0000_FE00);
		wr({`OBJ_MULTS, `SUB_CH1}, 32'h0000_0014);
		wr({`OBJ_DIVS, `SUB_CH1}, 32'h0000_03FF);
		wr({`OBJ_OFFSETS, `SUB_CH2}, 32'h0000_0005);
		wr({`OBJ_MULTS, `SUB_CH2}, 32'h0000_FFFD);
		wr({`OBJ_DIVS, `SUB_CH2}, 32'h0000_0002);
		rd({`OBJ_OFFSETS, `SUB_CH1}, 32'h0000_FE00);
		rd({`OBJ_DIVS, `SUB_CH2}, 32'h0000_0002);
		// channel 1 factors turn digits into volts: (count - 512) * 20 / 1023
		adc.send(1'b0, 10'h3FF);
		adc.send(1'b1, 10'h00A);
		adc.send(1'b0, 10'h000);
		// both channels now queue behind the first: channel 1 goes first
		wait_val(1'b0, scale(1023, -512, 20, 1023));
		check("scaled 2", 32'h0000_03FF, scaled_value_2);
		wait_val(1'b0, scale(0, -512, 20, 1023));
		check("scaled 2", 32'h0000_03FF, scaled_value_2);
		wait_val(1'b1, scale(10, 5, -3, 2));
	endtask

	task automatic t_zero_div();
		wr({`OBJ_DIVS, `SUB_CH1}, 32'h0000_0000);
		adc.send(1'b0, 10'h1F4);
		repeat (100) @(posedge clk_sys);
		#1;
		check("scaled 1", scale(0, -512, 20, 1023), scaled_value_1);
		check("scaled 2", scale(10, 5, -3, 2), scaled_value_2);
	endtask

	task automatic t_one_channel();
		@(posedge clk_sys);
		second_channel_fitted <= 1'b0;
		// current input: no mid-scale offset, count * 20 / 1023 milliamps
		wr({`OBJ_OFFSETS, `SUB_CH1}, 32'h0000_0000);
		wr({`OBJ_DIVS, `SUB_CH1}, 32'h0000_03FF);
		wr({`OBJ_MULTS, `SUB_CH2}, 32'h0000_0009);
		rd({`OBJ_VALUES, `SUB_CH2}, 32'h0000_0000);
		adc.send(1'b1, 10'h100);
		adc.send(1'b0, 10'h3FF);
		wait_val(1'b0, scale(1023, 0, 20, 1023));
		@(posedge clk_sys);
		second_channel_fitted <= 1'b1;
		rd({`OBJ_MULTS, `SUB_CH2}, 32'h0000_FFFD);
		rd({`OBJ_VALUES, `SUB_CH2}, scale(10, 5, -3, 2));
	endtask

	// ****************************************
	// run control
	// ****************************************
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		repeat (6) @(posedge clk_sys);
		rstn <= 1'b1;
		ce   <= 1'b1;
		t_reset_map();
		t_default();
		t_scale();
		t_zero_div();
		t_one_channel();
		give_verdict();
	end

	// whole run is well under 3000 cycles; this margin only catches hangs
	initial begin
		repeat (20000) @(posedge clk_sys);
		bad_count++;
		give_verdict();
	end
endmodule
